//--- inc/udsfc_regs.vh
`ifndef UDSFC_REGS_VH
`define UDSFC_REGS_VH
// Operation
// - 8-bit read-only request status, resets to 00H, bits 7,6,1,0 zero.
// - Bit 5 shows endpoint 4 read request, bit 3 endpoint 2.
// - Bit 4 shows endpoint 3 write request, bit 2 endpoint 1.
// - Setting write enable raises request at once, but only while the buffer is ready.
// - Bits of unsupported endpoints mean nothing and do nothing.
// - Stop bits 7,5,4,2 set when terminal count stops an active request.
// - Stop bits 6,3 mirror endpoint 4 and 2 short-packet stop signal.
// - Reading stop status clears it; interrupt status bits stay untouched.
// - Losing endpoint support clears its stop bits, interrupts are kept.
// - Write-only clear register reads 00H; ones clear, self-return, zeros ignored.
// - Bits 7,5 clear serial-side bulk IN counter and its NAK flag.
// - Serial-side bulk clear ignored during IN token with NAK set.
// - Bits 6,4 clear only the CPU-side bulk IN counter.
// - Bits 3,2 clear interrupt buffer and NAK, ignored during IN token with NAK set.
// - Bit 1 clears endpoint 0 transmit buffer and NAK, ignored during IN token with NAK set.
// - Bit 0 clears endpoint 0 receive; NAK clears only if hardware set.
// - Write enable requests while space exists; terminal count clears enable.
// - Read enable cleared by terminal count or by short-packet stop.

// Register addresses
`define UDSFC_ADDR_MODE 32'hFFFFFE26
`define UDSFC_ADDR_REQ_STAT 32'hFFFFFE27
`define UDSFC_ADDR_STOP_STAT 32'hFFFFFE28
`define UDSFC_ADDR_FIFO_CLR 32'hFFFFFE30
`define UDSFC_RESET_VAL 8'h00
`define UDSFC_READ_ZERO 8'h00

// Request status bit positions
`define UDSFC_RQ_EP1 2
`define UDSFC_RQ_EP4 5

// Stop status bit positions
`define UDSFC_ST_END1 2
`define UDSFC_ST_SHORT2 3
`define UDSFC_ST_END2 4
`define UDSFC_ST_END3 5
`define UDSFC_ST_SHORT4 6
`define UDSFC_ST_END4 7

// FIFO clear bit positions
`define UDSFC_FC_EP0RX 0
`define UDSFC_FC_EP0TX 1
`define UDSFC_FC_INTR1 2
`define UDSFC_FC_INTR2 3
`define UDSFC_FC_BI1CPU 4
`define UDSFC_FC_BI1SER 5
`define UDSFC_FC_BI2CPU 6
`define UDSFC_FC_BI2SER 7

// DMA mode and enable register bit positions
`define UDSFC_MD_MODE0 0
`define UDSFC_MD_MODE1 1
`define UDSFC_MD_RD_EP2 4
`define UDSFC_MD_RD_EP4 5
`define UDSFC_MD_WR_EP1 6
`define UDSFC_MD_WR_EP3 7

// Endpoint support vector positions
`define UDSFC_SUP_EP1 0
`define UDSFC_SUP_EP3 2
`define UDSFC_SUP_EP7 4
`define UDSFC_SUP_EP8 5
`endif

//--- hw/udsfc_chan.v
`timescale 1ns/10ps
module udsfc_chan #(
    parameter IS_READ = 0
) (
    // Clock and reset
    input wire mclk_i,
    input wire reset_i,
    // Firmware access to the enable bit
    input wire en_wr_i,
    input wire en_val_i,
    // Endpoint state
    input wire sup_i,
    input wire ready_i,
    input wire tc_i,
    input wire short_i,
    // Results
    output reg en_o,
    output reg req_o,
    output reg end_evt_o,
    output reg short_evt_o,
    output reg lost_o
);
    reg sup_q;
    reg next_en;
    wire rd_kind = (IS_READ != 0);
    wire lost = sup_q & ~sup_i;

    // Enable: firmware write wins, then hardware clears
    always @* begin
        next_en = en_o;
        if (en_wr_i) begin
            next_en = en_val_i & sup_i;
        end else if (tc_i | (rd_kind & short_i) | lost) begin
            next_en = 1'b0;
        end
    end

    // Request rises with the enable, no data-end qualification
    always @(posedge mclk_i) begin
        if (reset_i) begin
            sup_q <= 1'b0;
            en_o <= 1'b0;
            req_o <= 1'b0;
            end_evt_o <= 1'b0;
            short_evt_o <= 1'b0;
            lost_o <= 1'b0;
        end else begin
            sup_q <= sup_i;
            en_o <= next_en;
            req_o <= next_en & sup_i & ready_i;
            end_evt_o <= tc_i & req_o & sup_i;
            short_evt_o <= rd_kind & short_i & sup_i;
            lost_o <= lost;
        end
    end
endmodule

//--- hw/udsfc_clr.v
`timescale 1ns/10ps
module udsfc_clr (
    // Clock and reset
    input wire mclk_i,
    input wire reset_i,
    // Clear request and its guards
    input wire req_i,
    input wire sup_i,
    input wire busy_i,
    input wire nak_i,
    // Pulses to the buffer
    output reg clr_o,
    output reg nak_clr_o
);
    // A NAKed IN token in flight owns the buffer, so the clear is dropped
    wire go = req_i & sup_i & ~(busy_i & nak_i);

    always @(posedge mclk_i) begin
        if (reset_i) begin
            clr_o <= 1'b0;
            nak_clr_o <= 1'b0;
        end else begin
            clr_o <= go;
            nak_clr_o <= go & nak_i;
        end
    end
endmodule

//--- hw/udsfc_top.v
`timescale 1ns/10ps
`include "udsfc_regs.vh"
module udsfc_top (
    // Clock and reset
    input wire mclk_i,
    input wire reset_i,

    // CPU register access, 8-bit
    input wire [31:0] cpu_addr_i,
    input wire cpu_rd_i,
    input wire cpu_wr_i,
    input wire [7:0] cpu_wdata_i,
    output reg [7:0] cpu_rdata_o,

    // Endpoint support: ep1..ep4, ep7, ep8
    input wire [5:0] ep_sup_i,

    // DMA side: index 0..3 is endpoint 1..4
    input wire [3:0] dma_ready_i,
    input wire [3:0] dma_tc_i,
    input wire [1:0] short_packet_stop_signal_i,
    output wire [3:0] dma_req_o,
    output reg [1:0] dma_mode_o,

    // Stop events toward the interrupt logic
    output wire [3:0] dma_end_evt_o,
    output wire [1:0] short_evt_o,

    // Bulk IN buffers 1 and 2
    input wire [1:0] bulk_in_nak_flag_i,
    input wire [1:0] bulk_in_token_i,
    output wire [1:0] bulk_in_serial_side_clear_o,
    output reg [1:0] bulk_in_cpu_side_clear_o,
    output wire [1:0] bulk_in_nak_clr_o,

    // Interrupt buffers 1 and 2
    input wire [1:0] intr_nak_flag_i,
    input wire [1:0] intr_token_i,
    output wire [1:0] intr_buffer_clear_o,
    output wire [1:0] intr_nak_clr_o,

    // Endpoint 0 transmit buffer
    input wire ep0_tx_nak_flag_i,
    input wire ep0_in_token_i,
    output wire ep0_tx_buffer_clear_o,
    output wire ep0_tx_nak_clr_o,

    // Endpoint 0 receive buffer
    input wire ep0_rx_nak_flag_i,
    input wire ep0_rx_nak_by_fw_i,
    output reg ep0_rx_buffer_clear_o,
    output reg ep0_rx_nak_clr_o
);

    // Address decode
    wire hit_mode = (cpu_addr_i == `UDSFC_ADDR_MODE);
    wire hit_req = (cpu_addr_i == `UDSFC_ADDR_REQ_STAT);
    wire hit_stop = (cpu_addr_i == `UDSFC_ADDR_STOP_STAT);
    wire hit_fic = (cpu_addr_i == `UDSFC_ADDR_FIFO_CLR);
    wire wr_mode = cpu_wr_i & hit_mode;
    wire wr_fic = cpu_wr_i & hit_fic;
    wire rd_stop = cpu_rd_i & hit_stop;

    // Per-channel state passed to and gathered from the channel instances
    wire [3:0] ch_en;
    wire [3:0] ch_lost;
    wire [3:0] ch_sup;
    wire [3:0] ch_en_val;
    wire [3:0] ch_short;

    reg [7:0] dma_request_status;
    reg [7:0] dma_stop_status;
    reg [7:0] next_stop;
    reg [7:0] rd_mux;

    // Channel support and the mode-register bit owning each channel
    assign ch_sup = ep_sup_i[3:0];
    assign ch_en_val[0] = cpu_wdata_i[`UDSFC_MD_WR_EP1];
    assign ch_en_val[1] = cpu_wdata_i[`UDSFC_MD_RD_EP2];
    assign ch_en_val[2] = cpu_wdata_i[`UDSFC_MD_WR_EP3];
    assign ch_en_val[3] = cpu_wdata_i[`UDSFC_MD_RD_EP4];

    // Write channels never see a short-packet stop
    assign ch_short[0] = 1'b0;
    assign ch_short[1] = short_packet_stop_signal_i[0];
    assign ch_short[2] = 1'b0;
    assign ch_short[3] = short_packet_stop_signal_i[1];

    // One channel per endpoint; odd indices are the read endpoints 2 and 4
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_ch
            wire unused_short;
            udsfc_chan #(
                .IS_READ(gi % 2)
            ) u_chan (
                .mclk_i(mclk_i),
                .reset_i(reset_i),
                .en_wr_i(wr_mode),
                .en_val_i(ch_en_val[gi]),
                .sup_i(ch_sup[gi]),
                .ready_i(dma_ready_i[gi]),
                .tc_i(dma_tc_i[gi]),
                .short_i(ch_short[gi]),
                .en_o(ch_en[gi]),
                .req_o(dma_req_o[gi]),
                .end_evt_o(dma_end_evt_o[gi]),
                .short_evt_o(unused_short),
                .lost_o(ch_lost[gi])
            );
        end
    endgenerate

    // Only the read channels report short-packet stops
    assign short_evt_o[0] = g_ch[1].unused_short;
    assign short_evt_o[1] = g_ch[3].unused_short;

    // Transfer mode bits; bits 3 and 2 are held at zero
    always @(posedge mclk_i) begin
        if (reset_i) begin
            dma_mode_o <= 2'h0;
        end else if (wr_mode) begin
            dma_mode_o <= {cpu_wdata_i[`UDSFC_MD_MODE1],
                           cpu_wdata_i[`UDSFC_MD_MODE0]};
        end
    end

    // Request status mirrors the request flops, one cycle behind them
    always @(posedge mclk_i) begin
        if (reset_i) begin
            dma_request_status <= `UDSFC_RESET_VAL;
        end else begin
            dma_request_status <= {2'h0, dma_req_o, 2'h0};
        end
    end

    // Stop status: read clear first, then hardware sets win over it,
    // then loss of support clears last so stale stops never linger
    always @* begin
        next_stop = dma_stop_status;
        if (rd_stop) begin
            next_stop = `UDSFC_READ_ZERO;
        end
        if (dma_end_evt_o[0]) begin
            next_stop[`UDSFC_ST_END1] = 1'b1;
        end
        if (dma_end_evt_o[1]) begin
            next_stop[`UDSFC_ST_END2] = 1'b1;
        end
        if (dma_end_evt_o[2]) begin
            next_stop[`UDSFC_ST_END3] = 1'b1;
        end
        if (dma_end_evt_o[3]) begin
            next_stop[`UDSFC_ST_END4] = 1'b1;
        end
        if (short_evt_o[0]) begin
            next_stop[`UDSFC_ST_SHORT2] = 1'b1;
        end
        if (short_evt_o[1]) begin
            next_stop[`UDSFC_ST_SHORT4] = 1'b1;
        end
        if (ch_lost[0]) begin
            next_stop[`UDSFC_ST_END1] = 1'b0;
        end
        if (ch_lost[1]) begin
            next_stop[`UDSFC_ST_END2] = 1'b0;
            next_stop[`UDSFC_ST_SHORT2] = 1'b0;
        end
        if (ch_lost[2]) begin
            next_stop[`UDSFC_ST_END3] = 1'b0;
        end
        if (ch_lost[3]) begin
            next_stop[`UDSFC_ST_END4] = 1'b0;
            next_stop[`UDSFC_ST_SHORT4] = 1'b0;
        end
    end

    // Stop status register; the event outputs are not touched by a read
    always @(posedge mclk_i) begin
        if (reset_i) begin
            dma_stop_status <= `UDSFC_RESET_VAL;
        end else begin
            dma_stop_status <= next_stop;
        end
    end

    // Read mux; the clear register and unmapped addresses read zero
    always @* begin
        rd_mux = `UDSFC_READ_ZERO;
        if (hit_mode) begin
            rd_mux = {ch_en[2], ch_en[0], ch_en[3], ch_en[1],
                      2'h0, dma_mode_o};
        end else if (hit_req) begin
            rd_mux = dma_request_status;
        end else if (hit_stop) begin
            rd_mux = dma_stop_status;
        end else if (hit_fic) begin
            rd_mux = `UDSFC_READ_ZERO;
        end
    end

    // Read data is registered and held until the next read
    always @(posedge mclk_i) begin
        if (reset_i) begin
            cpu_rdata_o <= `UDSFC_READ_ZERO;
        end else if (cpu_rd_i) begin
            cpu_rdata_o <= rd_mux;
        end
    end

    // FIFO clear bits act as one-cycle strobes and are never stored,
    // so the register needs no self-clearing state of its own
    wire [7:0] fic = wr_fic ? cpu_wdata_i : 8'h00;

    // Serial-side bulk IN clears, guarded by NAKed IN tokens on ep1/ep3
    udsfc_clr u_bi1_ser (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .req_i(fic[`UDSFC_FC_BI1SER]),
        .sup_i(ep_sup_i[`UDSFC_SUP_EP1]),
        .busy_i(bulk_in_token_i[0]),
        .nak_i(bulk_in_nak_flag_i[0]),
        .clr_o(bulk_in_serial_side_clear_o[0]),
        .nak_clr_o(bulk_in_nak_clr_o[0])
    );

    udsfc_clr u_bi2_ser (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .req_i(fic[`UDSFC_FC_BI2SER]),
        .sup_i(ep_sup_i[`UDSFC_SUP_EP3]),
        .busy_i(bulk_in_token_i[1]),
        .nak_i(bulk_in_nak_flag_i[1]),
        .clr_o(bulk_in_serial_side_clear_o[1]),
        .nak_clr_o(bulk_in_nak_clr_o[1])
    );

    // Interrupt buffer clears, guarded by NAKed IN tokens on ep7/ep8
    udsfc_clr u_intr1 (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .req_i(fic[`UDSFC_FC_INTR1]),
        .sup_i(ep_sup_i[`UDSFC_SUP_EP7]),
        .busy_i(intr_token_i[0]),
        .nak_i(intr_nak_flag_i[0]),
        .clr_o(intr_buffer_clear_o[0]),
        .nak_clr_o(intr_nak_clr_o[0])
    );

    udsfc_clr u_intr2 (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .req_i(fic[`UDSFC_FC_INTR2]),
        .sup_i(ep_sup_i[`UDSFC_SUP_EP8]),
        .busy_i(intr_token_i[1]),
        .nak_i(intr_nak_flag_i[1]),
        .clr_o(intr_buffer_clear_o[1]),
        .nak_clr_o(intr_nak_clr_o[1])
    );

    // Endpoint 0 is always supported
    udsfc_clr u_ep0_tx (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .req_i(fic[`UDSFC_FC_EP0TX]),
        .sup_i(1'b1),
        .busy_i(ep0_in_token_i),
        .nak_i(ep0_tx_nak_flag_i),
        .clr_o(ep0_tx_buffer_clear_o),
        .nak_clr_o(ep0_tx_nak_clr_o)
    );

    // CPU-side bulk clears leave the serial half and its NAK alone;
    // firmware must drain the CPU half before a serial-only clear
    always @(posedge mclk_i) begin
        if (reset_i) begin
            bulk_in_cpu_side_clear_o <= 2'h0;
        end else begin
            bulk_in_cpu_side_clear_o[0] <=
                fic[`UDSFC_FC_BI1CPU] & ep_sup_i[`UDSFC_SUP_EP1];
            bulk_in_cpu_side_clear_o[1] <=
                fic[`UDSFC_FC_BI2CPU] & ep_sup_i[`UDSFC_SUP_EP3];
        end
    end

    // Receive clear; a firmware-set NAK survives it
    always @(posedge mclk_i) begin
        if (reset_i) begin
            ep0_rx_buffer_clear_o <= 1'b0;
            ep0_rx_nak_clr_o <= 1'b0;
        end else begin
            ep0_rx_buffer_clear_o <= fic[`UDSFC_FC_EP0RX];
            ep0_rx_nak_clr_o <= fic[`UDSFC_FC_EP0RX] &
                ep0_rx_nak_flag_i & ~ep0_rx_nak_by_fw_i;
        end
    end

endmodule

//--- verification/udsfc_top_sva.sv
`timescale 1ns/10ps
`include "udsfc_regs.vh"
module udsfc_sva (
    // Clock and reset
    input wire mclk_i, reset_i,
    // Register access
    input wire [31:0] cpu_addr_i,
    input wire cpu_rd_i, cpu_wr_i,
    input wire [7:0] cpu_wdata_i, cpu_rdata_o,
    // DMA side
    input wire [5:0] ep_sup_i,
    input wire [3:0] dma_ready_i, dma_tc_i, dma_req_o, dma_end_evt_o,
    input wire [1:0] short_packet_stop_signal_i, short_evt_o,
    // Buffer guards and clear pulses
    input wire [1:0] bulk_in_nak_flag_i, bulk_in_token_i, intr_nak_flag_i,
    input wire [1:0] intr_token_i, bulk_in_serial_side_clear_o,
    input wire [1:0] bulk_in_cpu_side_clear_o, bulk_in_nak_clr_o,
    input wire [1:0] intr_buffer_clear_o, intr_nak_clr_o,
    input wire ep0_tx_nak_flag_i, ep0_in_token_i, ep0_tx_buffer_clear_o,
    input wire ep0_tx_nak_clr_o, ep0_rx_nak_flag_i, ep0_rx_nak_by_fw_i,
    input wire ep0_rx_buffer_clear_o, ep0_rx_nak_clr_o
);
    // Decodes; the pulses they cause are judged one edge later
    wire wr_fc = cpu_wr_i && cpu_addr_i == `UDSFC_ADDR_FIFO_CLR;
    wire rd_fc = cpu_rd_i && cpu_addr_i == `UDSFC_ADDR_FIFO_CLR;
    wire rd_st = cpu_rd_i && cpu_addr_i == `UDSFC_ADDR_STOP_STAT;
    wire rd_rq = cpu_rd_i && cpu_addr_i == `UDSFC_ADDR_REQ_STAT;
    wire quiet = !(|{dma_end_evt_o, short_evt_o, dma_tc_i,
        short_packet_stop_signal_i});
    wire [3:0] ok = ep_sup_i[3:0] & dma_ready_i;
    wire [1:0] b_go = {cpu_wdata_i[7] & ep_sup_i[2],
        cpu_wdata_i[5] & ep_sup_i[0]} & {2{wr_fc}}
        & ~(bulk_in_token_i & bulk_in_nak_flag_i);
    wire [1:0] c_go = {cpu_wdata_i[6] & ep_sup_i[2],
        cpu_wdata_i[4] & ep_sup_i[0]} & {2{wr_fc}};
    wire [1:0] i_go = cpu_wdata_i[3:2] & ep_sup_i[5:4] & {2{wr_fc}}
        & ~(intr_token_i & intr_nak_flag_i);
    wire t_go = wr_fc & cpu_wdata_i[1] & ~(ep0_in_token_i & ep0_tx_nak_flag_i);
    wire r_go = wr_fc & cpu_wdata_i[0];

    default clocking dc @(posedge mclk_i);
    endclocking
    default disable iff (reset_i);

    a_req_gated: assert property ($stable(ok) |-> (dma_req_o & ~ok) == 0)
        else $error("request without support or space");
    a_tc_stops: assert property (!$past(cpu_wr_i) |->
        (dma_req_o & $past(dma_tc_i)) == 4'h0)
        else $error("request survived terminal count");
    a_end_cause: assert property (
        dma_end_evt_o == $past(dma_tc_i & dma_req_o & ep_sup_i[3:0]))
        else $error("end event without stopped request");
    a_short_mirror: assert property ($past(ep_sup_i[1] & ep_sup_i[3]) |->
        short_evt_o == $past(short_packet_stop_signal_i))
        else $error("short stop not mirrored");
    a_read_clears: assert property (rd_st && quiet ##1 quiet
        ##1 rd_st |=> cpu_rdata_o == 8'h00)
        else $error("stop status kept after read");
    a_req_view: assert property (rd_rq && $stable(dma_req_o) |=>
        cpu_rdata_o == {2'b00, $past(dma_req_o, 2), 2'b00})
        else $error("request status wrong");
    a_fifo_zero: assert property (rd_fc |=> cpu_rdata_o == 8'h00)
        else $error("fifo clear read not zero");
    a_bulk_serial: assert property (
        {bulk_in_serial_side_clear_o, bulk_in_nak_clr_o} ==
        $past({b_go, b_go & bulk_in_nak_flag_i}))
        else $error("serial side clear wrong");
    a_bulk_cpu: assert property (bulk_in_cpu_side_clear_o == $past(c_go))
        else $error("cpu side clear wrong");
    a_intr_clear: assert property (
        {intr_buffer_clear_o, intr_nak_clr_o} ==
        $past({i_go, i_go & intr_nak_flag_i}))
        else $error("interrupt buffer clear wrong");
    a_ep0_tx: assert property ({ep0_tx_buffer_clear_o, ep0_tx_nak_clr_o} ==
        $past({t_go, t_go & ep0_tx_nak_flag_i}))
        else $error("ep0 transmit clear wrong");
    a_ep0_rx: assert property ({ep0_rx_buffer_clear_o, ep0_rx_nak_clr_o} ==
        $past({r_go, r_go & ep0_rx_nak_flag_i & ~ep0_rx_nak_by_fw_i}))
        else $error("ep0 receive clear wrong");

    // Main scenarios reached
    c_tc_end: cover property (|dma_end_evt_o);
    c_short: cover property (|short_evt_o);
    c_blocked: cover property (wr_fc && cpu_wdata_i[7] && bulk_in_token_i[1]
        && bulk_in_nak_flag_i[1]);
endmodule

bind udsfc_top udsfc_sva sva_i (.mclk_i, .reset_i, .cpu_addr_i, .cpu_rd_i,
    .cpu_wr_i, .cpu_wdata_i, .cpu_rdata_o, .ep_sup_i, .dma_ready_i, .dma_tc_i,
    .dma_req_o, .dma_end_evt_o, .short_packet_stop_signal_i, .short_evt_o,
    .bulk_in_nak_flag_i, .bulk_in_token_i, .intr_nak_flag_i, .intr_token_i,
    .bulk_in_serial_side_clear_o, .bulk_in_cpu_side_clear_o,
    .bulk_in_nak_clr_o, .intr_buffer_clear_o, .intr_nak_clr_o,
    .ep0_tx_nak_flag_i, .ep0_in_token_i, .ep0_tx_buffer_clear_o,
    .ep0_tx_nak_clr_o, .ep0_rx_nak_flag_i, .ep0_rx_nak_by_fw_i,
    .ep0_rx_buffer_clear_o, .ep0_rx_nak_clr_o);

//--- verification/udsfc_dma_model.sv
`timescale 1ns/10ps
// DMA controller stand-in: once armed it grants one transfer per
// cycle of request and pulses terminal count after LEN grants
module udsfc_dma_model #(
    parameter LEN = 3
) (
    input wire mclk_i,
    input wire reset_i,
    input wire [3:0] req_i,
    input wire [3:0] arm_i,
    output reg [3:0] tc_o
);
    reg [3:0] armed;
    reg [7:0] cnt [0:3];
    integer i;
    initial tc_o = 4'h0;
    // Grant counting per channel; terminal count lasts one cycle only
    always @(posedge mclk_i) begin
        for (i = 0; i < 4; i = i + 1) begin
            tc_o[i] <= 1'b0;
            if (reset_i || arm_i[i]) begin
                armed[i] <= arm_i[i] && !reset_i;
                cnt[i] <= 8'h00;
            end else if (armed[i] && req_i[i]) begin
                cnt[i] <= cnt[i] + 8'h01;
                if (cnt[i] == LEN - 1) begin
                    tc_o[i] <= 1'b1;
                    armed[i] <= 1'b0;
                end
            end
        end
    end
endmodule

//--- verification/test_usb_endpoint_dma_status_fifo_clear.sv
`timescale 1ns/10ps
`include "udsfc_regs.vh"
module test_usb_endpoint_dma_status_fifo_clear;
    // Stimulus, valued at time zero
    reg mclk_i = 1'b0;
    reg reset_i = 1'b1;
    reg cpu_rd_i = 1'b0;
    reg cpu_wr_i = 1'b0;
    reg [31:0] cpu_addr_i = 32'h0;
    reg [7:0] cpu_wdata_i = 8'h00;
    reg [5:0] ep_sup_i = 6'h3F;
    reg [3:0] dma_ready_i = 4'h0;
    reg [3:0] arm = 4'h0;
    reg [1:0] short_packet_stop_signal_i = 2'h0;
    reg [1:0] bulk_in_nak_flag_i = 2'h0, bulk_in_token_i = 2'h0;
    reg [1:0] intr_nak_flag_i = 2'h0, intr_token_i = 2'h0;
    reg ep0_tx_nak_flag_i = 1'b0, ep0_in_token_i = 1'b0;
    reg ep0_rx_nak_flag_i = 1'b0, ep0_rx_nak_by_fw_i = 1'b0;
    // Design and DMA model outputs
    wire [7:0] cpu_rdata_o;
    wire [3:0] dma_req_o, dma_tc_i, dma_end_evt_o;
    wire [1:0] dma_mode_o, short_evt_o, bulk_in_serial_side_clear_o;
    wire [1:0] bulk_in_cpu_side_clear_o, bulk_in_nak_clr_o;
    wire [1:0] intr_buffer_clear_o, intr_nak_clr_o;
    wire ep0_tx_buffer_clear_o, ep0_tx_nak_clr_o;
    wire ep0_rx_buffer_clear_o, ep0_rx_nak_clr_o;
    // Bookkeeping
    integer bad_count = 0, cmp_count = 0, cyc = 0, i, k;
    reg [31:0] r;
    reg [7:0] m;
    reg [13:0] snap;

    udsfc_top dut (.mclk_i, .reset_i, .cpu_addr_i, .cpu_rd_i, .cpu_wr_i,
        .cpu_wdata_i, .cpu_rdata_o, .ep_sup_i, .dma_ready_i, .dma_tc_i,
        .short_packet_stop_signal_i, .dma_req_o, .dma_mode_o, .dma_end_evt_o,
        .short_evt_o, .bulk_in_nak_flag_i, .bulk_in_token_i,
        .bulk_in_serial_side_clear_o, .bulk_in_cpu_side_clear_o,
        .bulk_in_nak_clr_o, .intr_nak_flag_i, .intr_token_i,
        .intr_buffer_clear_o, .intr_nak_clr_o, .ep0_tx_nak_flag_i,
        .ep0_in_token_i, .ep0_tx_buffer_clear_o, .ep0_tx_nak_clr_o,
        .ep0_rx_nak_flag_i, .ep0_rx_nak_by_fw_i, .ep0_rx_buffer_clear_o,
        .ep0_rx_nak_clr_o);
    udsfc_dma_model #(.LEN(3)) dma (.mclk_i(mclk_i), .reset_i(reset_i),
        .req_i(dma_req_o), .arm_i(arm), .tc_o(dma_tc_i));

    // Clock, 40 ns period
    initial begin
        forever #20 mclk_i = ~mclk_i;
    end

    // A hang is cut off far beyond the roughly 600 cycles needed
    always @(posedge mclk_i) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            bad_count = bad_count + 1;
            stop_test;
        end
    end

    task stop_test;
        begin
            $display("compares %0d mismatches %0d", cmp_count, bad_count);
            if (bad_count == 0 && cmp_count > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask

    task chk(input string nm, input [15:0] seen, input [15:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("BAD %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask

    // One register cycle; strobe stands for exactly the taking edge
    task bus(input wr, input [31:0] a, input [7:0] d);
        begin
            @(posedge mclk_i);
            #1;
            cpu_addr_i = a;
            cpu_wdata_i = d;
            cpu_wr_i = wr;
            cpu_rd_i = !wr;
            @(posedge mclk_i);
            #1;
            cpu_wr_i = 1'b0;
            cpu_rd_i = 1'b0;
            snap = {bulk_in_serial_side_clear_o, bulk_in_cpu_side_clear_o,
                bulk_in_nak_clr_o, intr_buffer_clear_o, intr_nak_clr_o,
                ep0_tx_buffer_clear_o, ep0_tx_nak_clr_o,
                ep0_rx_buffer_clear_o, ep0_rx_nak_clr_o};
        end
    endtask

    task rdc(input string nm, input [31:0] a, input [7:0] exp);
        begin
            bus(1'b0, a, 8'h00);
            chk(nm, cpu_rdata_o, exp);
        end
    endtask

    // Bounded wait until every request has dropped
    task wait_idle;
        begin
            k = 0;
            while (dma_req_o !== 4'h0 && k < 40) begin
                @(posedge mclk_i);
                #1;
                k = k + 1;
            end
        end
    endtask

    // Requests expected from enables, support and buffer state
    function [3:0] f_req(input [7:0] md);
        f_req = {md[5], md[7], md[4], md[6]} & ep_sup_i[3:0] & dma_ready_i;
    endfunction

    // Clear pulses expected from one write, with the token guards
    function [13:0] f_clr(input [7:0] d);
        reg [1:0] s, t;
        reg x;
        begin
            s = {d[7] & ep_sup_i[2], d[5] & ep_sup_i[0]}
                & ~(bulk_in_token_i & bulk_in_nak_flag_i);
            t = d[3:2] & ep_sup_i[5:4] & ~(intr_token_i & intr_nak_flag_i);
            x = d[1] & ~(ep0_in_token_i & ep0_tx_nak_flag_i);
            f_clr = {s, d[6] & ep_sup_i[2], d[4] & ep_sup_i[0],
                s & bulk_in_nak_flag_i, t, t & intr_nak_flag_i,
                x, x & ep0_tx_nak_flag_i, d[0],
                d[0] & ep0_rx_nak_flag_i & ~ep0_rx_nak_by_fw_i};
        end
    endfunction

    // Main sequence
    initial begin
        void'($urandom(32'h619C500E));
        repeat (8) @(posedge mclk_i);
        #1;
        reset_i = 1'b0;
        bus(1'b1, `UDSFC_ADDR_REQ_STAT, 8'hFF);
        bus(1'b1, `UDSFC_ADDR_STOP_STAT, 8'hFF);
        rdc("rq", `UDSFC_ADDR_REQ_STAT, 8'h00);
        rdc("st", `UDSFC_ADDR_STOP_STAT, 8'h00);
        rdc("unmapped", 32'hFFFFFE29, 8'h00);
        $display("test reset done");
        for (i = 0; i < 24; i = i + 1) begin
            r = $urandom;
            ep_sup_i = (i == 0) ? 6'h3F : r[5:0];
            dma_ready_i = (i == 0) ? 4'hF : r[9:6];
            m = (i == 0) ? 8'hF0 : (r[17:10] & 8'hF3);
            bus(1'b1, `UDSFC_ADDR_MODE, m);
            chk("req", dma_req_o, f_req(m));
            chk("mode", dma_mode_o, m[1:0]);
            rdc("rq", `UDSFC_ADDR_REQ_STAT, {2'b00, f_req(m), 2'b00});
            rdc("rq", `UDSFC_ADDR_REQ_STAT, {2'b00, f_req(m), 2'b00});
        end
        $display("test enables done");
        ep_sup_i = 6'h3F;
        dma_ready_i = 4'hF;
        bus(1'b1, `UDSFC_ADDR_MODE, 8'hF0);
        arm = 4'hF;
        @(posedge mclk_i);
        #1;
        arm = 4'h0;
        wait_idle;
        chk("req", dma_req_o, 4'h0);
        rdc("st", `UDSFC_ADDR_STOP_STAT, 8'hB4);
        rdc("st", `UDSFC_ADDR_STOP_STAT, 8'h00);
        $display("test terminal count done");
        bus(1'b1, `UDSFC_ADDR_MODE, 8'h30);
        short_packet_stop_signal_i = 2'b01;
        @(posedge mclk_i);
        #1;
        short_packet_stop_signal_i = 2'b00;
        @(posedge mclk_i);
        #1;
        chk("req", dma_req_o, 4'h8);
        rdc("st", `UDSFC_ADDR_STOP_STAT, 8'h08);
        rdc("st", `UDSFC_ADDR_STOP_STAT, 8'h00);
        $display("test short stop done");
        bus(1'b1, `UDSFC_ADDR_MODE, 8'h40);
        arm = 4'h1;
        @(posedge mclk_i);
        #1;
        arm = 4'h0;
        wait_idle;
        ep_sup_i = 6'h3E;
        @(posedge mclk_i);
        #1;
        rdc("st", `UDSFC_ADDR_STOP_STAT, 8'h00);
        ep_sup_i = 6'h3F;
        bus(1'b1, `UDSFC_ADDR_MODE, 8'h40);
        ep_sup_i = 6'h3E;
        @(posedge mclk_i);
        #1;
        chk("req", dma_req_o, 4'h0);
        $display("test support loss done");
        bus(1'b1, `UDSFC_ADDR_FIFO_CLR, 8'h50);
        bus(1'b1, `UDSFC_ADDR_FIFO_CLR, 8'hA0);
        for (i = 0; i < 200; i = i + 1) begin
            r = $urandom;
            if (i % 4 == 0)
                r[11:0] = 12'hFFE;
            {bulk_in_nak_flag_i, bulk_in_token_i, intr_nak_flag_i,
                intr_token_i, ep0_tx_nak_flag_i, ep0_in_token_i,
                ep0_rx_nak_flag_i, ep0_rx_nak_by_fw_i} = r[11:0];
            ep_sup_i = (i % 8 == 1) ? 6'h3F : r[17:12];
            m = (i == 2) ? 8'h00 : r[25:18];
            bus(1'b1, `UDSFC_ADDR_FIFO_CLR, m);
            chk("clears", snap, f_clr(m));
        end
        rdc("fc", `UDSFC_ADDR_FIFO_CLR, 8'h00);
        $display("test fifo clears done");
        stop_test;
    end
endmodule
